/* hw/smc_pkg.sv */
// package: sleep controller constants, register map and encodings
package smc_pkg;

	// ----------------------------------------------------------------
	// register map (byte offsets on the plain register port)
	// ----------------------------------------------------------------
	localparam logic [7:0] SMC_SLEEP_CTRL_OFS = 8'h33;
	localparam logic [7:0] SMC_CLK_GATE_OFS = 8'h64;
	localparam logic [7:0] SMC_STATUS_OFS = 8'h65;

	// sleep control fields and reset values
	localparam int SMC_SLEEP_EN_BIT = 0;
	localparam int SMC_MODE_LSB = 1;
	localparam int SMC_MODE_MSB = 3;
	localparam logic [3:0] SMC_SLEEP_CTRL_RST = 4'h0;
	localparam logic [7:0] SMC_CLK_GATE_RST = 8'h00;
	// bit 4 of the clock gate register is reserved and reads zero
	localparam logic [7:0] SMC_CLK_GATE_MASK = 8'hef;

	// ----------------------------------------------------------------
	// cycle counts
	// ----------------------------------------------------------------
	localparam int SMC_HALT_CYC = 4;
	localparam int SMC_STANDBY_WAKE_CYC = 6;
	localparam int SMC_CNT_W = 16;

	// ----------------------------------------------------------------
	// sleep mode codes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SMC_M_IDLE = 3'h0,
		SMC_M_ADCQ = 3'h1,
		SMC_M_PDOWN = 3'h2,
		SMC_M_PSAVE = 3'h3,
		SMC_M_RSV4 = 3'h4,
		SMC_M_RSV5 = 3'h5,
		SMC_M_STBY = 3'h6,
		SMC_M_XSTBY = 3'h7
	} smc_mode_e;

	typedef enum logic [1:0] {
		SMC_ST_RUN = 2'b00,
		SMC_ST_SLEEP = 2'b01,
		SMC_ST_START = 2'b10,
		SMC_ST_HALT = 2'b11
	} smc_state_e;

endpackage

/* hw/smc_wake_qual.sv */
// wake source qualification per sleep mode
`timescale 1ns/1ps
module smc_wake_qual
	import smc_pkg::*;
(
	// mode and configuration
	input wire logic [2:0] mode_i,
	input wire logic gie_i,
	input wire logic t2_enabled_i,
	input wire logic [1:0] t2_mask_i,
	// sources
	input wire logic irq_any_i,
	input wire logic adc_done_i,
	input wire logic two_wire_irq_i,
	input wire logic two_wire_match_i,
	input wire logic t2_irq_i,
	input wire logic [1:0] t2_evt_i,
	input wire logic spm_ready_i,
	input wire logic wdog_irq_i,
	input wire logic [7:0] ext_level_i,
	input wire logic [7:0] ext_any_i,
	input wire logic pin_change_i,
	// result
	output logic wake_o
);
	logic deep_src;
	logic t2_wake;

	always_comb begin
		// upper lines only count as level wakes outside idle
		deep_src = two_wire_match_i | (|ext_level_i[7:4]) | (|ext_any_i[3:0])
			| pin_change_i;
		t2_wake = t2_enabled_i & gie_i & (|(t2_mask_i & t2_evt_i));
		unique case (smc_mode_e'(mode_i))
			SMC_M_IDLE: wake_o = irq_any_i;
			SMC_M_ADCQ: wake_o = adc_done_i | wdog_irq_i | two_wire_irq_i | t2_irq_i | spm_ready_i
				| (|ext_level_i[7:4]) | pin_change_i;
			SMC_M_PDOWN, SMC_M_STBY: wake_o = deep_src;
			SMC_M_PSAVE, SMC_M_XSTBY: wake_o = deep_src | t2_wake;
			default: wake_o = 1'b0;
		endcase
	end

endmodule // smc_wake_qual

/* hw/smc_periph_gate.sv */
// per-peripheral clock gate and register access block
`timescale 1ns/1ps
module smc_periph_gate #(
	parameter int N = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic [N-1:0] gate_i,
	input wire logic io_run_i,
	input wire logic [N-1:0] acc_req_i,
	// result
	output logic [N-1:0] clk_en_o,
	output logic [N-1:0] acc_ok_o
);
	logic [N-1:0] clk_en_ff;
	logic [N-1:0] acc_ok_ff;
	logic [N-1:0] nxt_clk_en;
	logic [N-1:0] nxt_acc_ok;

	if (N < 1) begin : g_bad_n
		$error("N must be at least 1");
	end

	always_comb begin
		// gated peripherals freeze; ungating resumes the same state
		nxt_clk_en = ~gate_i & {N{io_run_i}};
		// a gated peripheral's registers are neither read nor written
		nxt_acc_ok = acc_req_i & ~gate_i;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			clk_en_ff <= '1;
			acc_ok_ff <= '0;
		end else begin
			clk_en_ff <= nxt_clk_en;
			acc_ok_ff <= nxt_acc_ok;
		end
	end

	assign clk_en_o = clk_en_ff;
	assign acc_ok_o = acc_ok_ff;

endmodule // smc_periph_gate

/* hw/smc_sleep_ctrl.sv */
// sleep mode controller: sleep entry, clock domain gating, wake-up sequence
`timescale 1ns/1ps
// What this block does
// - sleep only on instruction with enable set
// - four halt cycles after start-up, then handler
// - register file and SRAM untouched by sleep
// - reset during sleep restarts at reset vector
// - idle stops core and flash clocks
// - idle wakes on any enabled interrupt
// - converter enabled: conversion starts at idle or converter-quiet entry
// - converter-quiet stops io, core, flash clocks
// - converter-quiet wakes only on listed sources
// - power-down stops oscillator and all clocks
// - power-down wakes only on listed sources
// - power-down wake waits start-up delay
// - power-save adds timer2 wake when enabled
// - power-save oscillators follow timer2 clocking
// - standby keeps oscillator, six cycle wake
// - extended standby keeps oscillator, six cycles
// - timer oscillator only in async timer2
// - upper external lines wake only level-sensitive
// - gate bit stops clock, blocks registers
// - clearing gate bit resumes frozen state
// - control register layout, reset zero
module smc_sleep_ctrl
	import smc_pkg::*;
#(
	parameter int STARTUP_CYCLES = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// core handshake
	input wire logic sleep_instr_i,
	output logic core_halt_o,
	output logic wake_irq_o,
	output logic reset_vector_o,
	// configuration from other units
	input wire logic adc_enabled_i,
	input wire logic xtal_selected_i,
	input wire logic t2_enabled_i,
	input wire logic t2_async_i,
	input wire logic [1:0] t2_mask_i,
	input wire logic gie_i,
	// wake sources on the core clock
	input wire logic irq_any_i,
	input wire logic adc_done_i,
	input wire logic two_wire_irq_i,
	input wire logic two_wire_match_i,
	input wire logic t2_irq_i,
	input wire logic [1:0] t2_evt_i,
	input wire logic spm_ready_i,
	input wire logic wdog_irq_i,
	input wire logic wdog_reset_i,
	input wire logic bor_reset_i,
	// wake sources from pins
	input wire logic [7:0] ext_level_i,
	input wire logic [7:0] ext_any_i,
	input wire logic pin_change_i,
	input wire logic ext_reset_i,
	// clock domain enables
	output logic core_clk_en_o,
	output logic flash_clk_en_o,
	output logic io_clk_en_o,
	output logic adc_clk_en_o,
	output logic async_clk_en_o,
	output logic main_osc_en_o,
	output logic timer_osc_en_o,
	output logic t2_sync_clk_en_o,
	output logic adc_start_o,
	// peripheral gating
	input wire logic [7:0] periph_acc_i,
	output logic [7:0] periph_clk_en_o,
	output logic [7:0] periph_acc_ok_o
);

	// ----------------------------------------------------------------
	// elaboration checks and derived counts
	// ----------------------------------------------------------------
	localparam logic [SMC_CNT_W-1:0] START_LOAD = SMC_CNT_W'(STARTUP_CYCLES - 1);
	localparam logic [SMC_CNT_W-1:0] STBY_LOAD = SMC_CNT_W'(SMC_STANDBY_WAKE_CYC - 1);
	localparam logic [SMC_CNT_W-1:0] HALT_LOAD = SMC_CNT_W'(SMC_HALT_CYC - 1);

	if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535) begin : g_bad_startup
		$error("STARTUP_CYCLES must lie in 1..65535");
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [17:0] pin_s1_ff;
	logic [17:0] pin_s2_ff;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
		end else begin
			pin_s1_ff <= {ext_reset_i, pin_change_i, ext_any_i, ext_level_i};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	logic [7:0] ext_level_s;
	logic [7:0] ext_any_s;
	logic pin_change_s;
	logic any_reset;
	assign ext_level_s = pin_s2_ff[7:0];
	assign ext_any_s = pin_s2_ff[15:8];
	assign pin_change_s = pin_s2_ff[16];
	assign any_reset = pin_s2_ff[17] | wdog_reset_i | bor_reset_i;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [3:0] sleep_ctrl_ff;
	logic [7:0] clk_gate_ff;
	logic [7:0] rdata_ff;
	logic [3:0] nxt_sleep_ctrl;
	logic [7:0] nxt_clk_gate;
	logic [7:0] nxt_rdata;
	smc_state_e state_ff;
	smc_state_e nxt_state;
	logic [2:0] mode_ff;

	always_comb begin
		nxt_sleep_ctrl = sleep_ctrl_ff;
		nxt_clk_gate = clk_gate_ff;
		nxt_rdata = 8'h00;
		if (reg_wr_i) begin
			if (reg_addr_i == SMC_SLEEP_CTRL_OFS) begin
				nxt_sleep_ctrl = reg_wdata_i[3:0];
			end
			if (reg_addr_i == SMC_CLK_GATE_OFS) begin
				nxt_clk_gate = reg_wdata_i & SMC_CLK_GATE_MASK;
			end
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				SMC_SLEEP_CTRL_OFS: nxt_rdata = {4'h0, sleep_ctrl_ff};
				SMC_CLK_GATE_OFS: nxt_rdata = clk_gate_ff;
				SMC_STATUS_OFS: nxt_rdata = {3'h0, mode_ff, state_ff};
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sleep_ctrl_ff <= SMC_SLEEP_CTRL_RST;
			clk_gate_ff <= SMC_CLK_GATE_RST;
			rdata_ff <= 8'h00;
		end else begin
			sleep_ctrl_ff <= nxt_sleep_ctrl;
			clk_gate_ff <= nxt_clk_gate;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata_o = rdata_ff;

	// ----------------------------------------------------------------
	// wake qualification
	// ----------------------------------------------------------------
	logic wake_src;

	smc_wake_qual u_wake (
		.mode_i(mode_ff),
		.gie_i(gie_i),
		.t2_enabled_i(t2_enabled_i),
		.t2_mask_i(t2_mask_i),
		.irq_any_i(irq_any_i),
		.adc_done_i(adc_done_i),
		.two_wire_irq_i(two_wire_irq_i),
		.two_wire_match_i(two_wire_match_i),
		.t2_irq_i(t2_irq_i),
		.t2_evt_i(t2_evt_i),
		.spm_ready_i(spm_ready_i),
		.wdog_irq_i(wdog_irq_i),
		.ext_level_i(ext_level_s),
		.ext_any_i(ext_any_s),
		.pin_change_i(pin_change_s),
		.wake_o(wake_src)
	);

	// ----------------------------------------------------------------
	// sleep sequence
	// ----------------------------------------------------------------
	logic [SMC_CNT_W-1:0] cnt_ff;
	logic [SMC_CNT_W-1:0] nxt_cnt;
	logic [2:0] nxt_mode;
	logic halt_ff;
	logic wake_irq_ff;
	logic rst_vec_ff;
	logic adc_start_ff;
	logic nxt_wake_irq;
	logic nxt_rst_vec;
	logic nxt_adc_start;
	logic sel_mode_ok;
	logic [2:0] sel_mode;

	always_comb begin
		sel_mode = sleep_ctrl_ff[SMC_MODE_MSB:SMC_MODE_LSB];
		// standby codes need a crystal; reserved codes never sleep
		unique case (smc_mode_e'(sel_mode))
			SMC_M_RSV4, SMC_M_RSV5: sel_mode_ok = 1'b0;
			SMC_M_STBY, SMC_M_XSTBY: sel_mode_ok = xtal_selected_i;
			default: sel_mode_ok = 1'b1;
		endcase
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_mode = mode_ff;
		nxt_wake_irq = 1'b0;
		nxt_rst_vec = 1'b0;
		nxt_adc_start = 1'b0;
		unique case (state_ff)
			SMC_ST_RUN: begin
				if (sleep_instr_i && sleep_ctrl_ff[SMC_SLEEP_EN_BIT] && sel_mode_ok) begin
					nxt_state = SMC_ST_SLEEP;
					nxt_mode = sel_mode;
					nxt_adc_start = adc_enabled_i
						&& (sel_mode == SMC_M_IDLE || sel_mode == SMC_M_ADCQ);
				end
			end
			SMC_ST_SLEEP: begin
				// only clocks stop here; storage keeps its contents
				if (any_reset) begin
					nxt_state = SMC_ST_RUN;
					nxt_rst_vec = 1'b1;
				end else if (wake_src) begin
					unique case (smc_mode_e'(mode_ff))
						SMC_M_PDOWN, SMC_M_PSAVE: begin
							nxt_state = SMC_ST_START;
							nxt_cnt = START_LOAD;
						end
						SMC_M_STBY, SMC_M_XSTBY: begin
							nxt_state = SMC_ST_START;
							nxt_cnt = STBY_LOAD;
						end
						default: begin
							nxt_state = SMC_ST_HALT;
							nxt_cnt = HALT_LOAD;
						end
					endcase
				end
			end
			SMC_ST_START: begin
				if (any_reset) begin
					nxt_state = SMC_ST_RUN;
					nxt_rst_vec = 1'b1;
				end else if (cnt_ff == '0) begin
					nxt_state = SMC_ST_HALT;
					nxt_cnt = HALT_LOAD;
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			SMC_ST_HALT: begin
				if (any_reset) begin
					nxt_state = SMC_ST_RUN;
					nxt_rst_vec = 1'b1;
				end else if (cnt_ff == '0) begin
					nxt_state = SMC_ST_RUN;
					nxt_wake_irq = 1'b1;
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_ff <= SMC_ST_RUN;
			cnt_ff <= '0;
			mode_ff <= 3'h0;
			halt_ff <= 1'b0;
			wake_irq_ff <= 1'b0;
			rst_vec_ff <= 1'b0;
			adc_start_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			mode_ff <= nxt_mode;
			halt_ff <= (nxt_state != SMC_ST_RUN);
			wake_irq_ff <= nxt_wake_irq;
			rst_vec_ff <= nxt_rst_vec;
			adc_start_ff <= nxt_adc_start;
		end
	end

	assign core_halt_o = halt_ff;
	assign wake_irq_o = wake_irq_ff;
	assign reset_vector_o = rst_vec_ff;
	assign adc_start_o = adc_start_ff;

	// ----------------------------------------------------------------
	// clock domain enables
	// ----------------------------------------------------------------
	// the core and flash stay stopped through start-up and halt; the other domains run again
	logic [7:0] clk_ff;
	logic [7:0] nxt_clk;

	always_comb begin
		// order: core, flash, io, adc, async, main osc, timer osc, t2 sync
		nxt_clk = {5'b11111, 1'b1, t2_async_i, 1'b0};
		if (nxt_state == SMC_ST_SLEEP) begin
			unique case (smc_mode_e'(nxt_mode))
				SMC_M_IDLE: nxt_clk = {4'b0011, t2_async_i, 1'b1, t2_async_i, 1'b0};
				SMC_M_ADCQ: nxt_clk = {4'b0001, t2_async_i, 1'b1, t2_async_i, 1'b0};
				SMC_M_PDOWN: nxt_clk = 8'h00;
				SMC_M_PSAVE: nxt_clk = {4'b0000, t2_async_i,
					t2_enabled_i & ~t2_async_i, t2_async_i,
					t2_enabled_i & ~t2_async_i};
				SMC_M_STBY: nxt_clk = {5'b00000, 1'b1, 2'b00};
				SMC_M_XSTBY: nxt_clk = {4'b0000, t2_async_i, 1'b1, t2_async_i,
					t2_enabled_i & ~t2_async_i};
				default: nxt_clk = 8'h00;
			endcase
		end else if (nxt_state != SMC_ST_RUN) begin
			nxt_clk = {5'b00111, 1'b1, t2_async_i, 1'b0};
		end
		nxt_clk[7:6] = (nxt_state == SMC_ST_RUN) ? 2'b11 : 2'b00;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			clk_ff <= 8'hfc;
		end else begin
			clk_ff <= nxt_clk;
		end
	end

	assign core_clk_en_o = clk_ff[7];
	assign flash_clk_en_o = clk_ff[6];
	assign io_clk_en_o = clk_ff[5];
	assign adc_clk_en_o = clk_ff[4];
	assign async_clk_en_o = clk_ff[3];
	assign main_osc_en_o = clk_ff[2];
	assign timer_osc_en_o = clk_ff[1];
	assign t2_sync_clk_en_o = clk_ff[0];

	// ----------------------------------------------------------------
	// peripheral clock gating
	// ----------------------------------------------------------------
	// software should quiesce a peripheral before gating it
	smc_periph_gate #(.N(8)) u_gate (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.gate_i(clk_gate_ff),
		.io_run_i(nxt_clk[5]),
		.acc_req_i(periph_acc_i),
		.clk_en_o(periph_clk_en_o),
		.acc_ok_o(periph_acc_ok_o)
	);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_sleep_entry: assert property ((state_ff == SMC_ST_RUN) && sleep_instr_i
		&& !sleep_ctrl_ff[SMC_SLEEP_EN_BIT] |=> state_ff == SMC_ST_RUN)
		else $error("slept without sleep enable");
	a_halt_four: assert property ($rose(state_ff == SMC_ST_HALT) && !any_reset
		##1 !any_reset [*3] |=> wake_irq_o)
		else $error("handler not released four cycles after start-up");
	a_reset_vector: assert property ((state_ff != SMC_ST_RUN) && any_reset
		|=> reset_vector_o && state_ff == SMC_ST_RUN)
		else $error("reset in sleep did not restart at vector");
	a_idle_clocks: assert property ((state_ff == SMC_ST_SLEEP) && mode_ff == SMC_M_IDLE
		|-> !core_clk_en_o && !flash_clk_en_o && io_clk_en_o && main_osc_en_o)
		else $error("idle clock domains wrong");
	a_adc_trigger: assert property ($rose(state_ff == SMC_ST_SLEEP)
		|-> adc_start_o == ($past(adc_enabled_i) && (mode_ff == SMC_M_IDLE || mode_ff == SMC_M_ADCQ)))
		else $error("conversion trigger at sleep entry wrong");
	a_adcq_clocks: assert property ((state_ff == SMC_ST_SLEEP) && mode_ff == SMC_M_ADCQ
		|-> !io_clk_en_o && adc_clk_en_o && main_osc_en_o)
		else $error("converter-quiet clock domains wrong");
	a_pdown_clocks: assert property ((state_ff == SMC_ST_SLEEP) && mode_ff == SMC_M_PDOWN
		|-> clk_ff == 8'h00)
		else $error("power-down left a clock running");
	a_startup_wait: assert property ($rose(state_ff == SMC_ST_START) && mode_ff == SMC_M_STBY
		&& !any_reset ##1 !any_reset [*5] |=> state_ff == SMC_ST_HALT)
		else $error("standby wake did not take six cycles");
	a_reserved_mode: assert property ((state_ff == SMC_ST_RUN) && sleep_instr_i
		&& sleep_ctrl_ff[3:2] == 2'b10 |=> state_ff == SMC_ST_RUN && core_clk_en_o)
		else $error("reserved mode code entered sleep");
	a_gate_access: assert property (periph_acc_i[0] && clk_gate_ff[0]
		|=> !periph_acc_ok_o[0])
		else $error("gated peripheral register reached");

	c_idle_wake: cover property ((state_ff == SMC_ST_SLEEP) && mode_ff == SMC_M_IDLE ##[1:50] wake_irq_o);
	c_pdown_wake: cover property ((state_ff == SMC_ST_START) && mode_ff == SMC_M_PDOWN ##[1:100] wake_irq_o);
	c_reset_wake: cover property (reset_vector_o);
	c_xstby_wake: cover property ((state_ff == SMC_ST_SLEEP) && mode_ff == SMC_M_XSTBY ##[1:50] wake_irq_o);

endmodule // smc_sleep_ctrl

/* testbench/smc_core_model.sv */
// core-side model: issues sleep instructions and counts wake-up outcomes
`timescale 1ns/1ps
module smc_core_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// request from the bench
	input wire logic go_i,
	// controller answers
	input wire logic core_halt_i,
	input wire logic wake_irq_i,
	input wire logic reset_vector_i,
	// core outputs
	output logic sleep_instr_o,
	output logic [7:0] wake_cnt_o,
	output logic [7:0] rv_cnt_o
);
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sleep_instr_o <= 1'b0;
			wake_cnt_o <= 8'h00;
			rv_cnt_o <= 8'h00;
		end else begin
			// a halted core executes nothing, so no sleep is issued then
			sleep_instr_o <= go_i & ~core_halt_i;
			wake_cnt_o <= wake_cnt_o + {7'h00, wake_irq_i};
			rv_cnt_o <= rv_cnt_o + {7'h00, reset_vector_i};
		end
	end
endmodule // smc_core_model

/* testbench/smc_sleep_ctrl_tb.sv */
// self-checking bench for the sleep mode controller
`timescale 1ns/1ps
module smc_sleep_ctrl_tb;
	import smc_pkg::*;
	logic clk_i, rst_n, wr_s, rd_s, go, sl, halt, wake, rv, ast;
	logic [7:0] addr, wdata, rdata, en, pclk, aok, acc, wc, rvc;
	// cfg: adc_en, xtal, t2_en, t2_async, gie, mask[1:0]
	logic [6:0] cfg;
	logic [28:0] src;
	int fail_count, checked, cyc;
	// ------------------------------------------------------------
	// instances
	// ------------------------------------------------------------
	smc_sleep_ctrl #(.STARTUP_CYCLES(4)) i_smc_sleep_ctrl (
		.clk_i(clk_i), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .sleep_instr_i(sl),
		.core_halt_o(halt), .wake_irq_o(wake), .reset_vector_o(rv),
		.adc_enabled_i(cfg[0]), .xtal_selected_i(cfg[1]), .t2_enabled_i(cfg[2]),
		.t2_async_i(cfg[3]), .gie_i(cfg[4]), .t2_mask_i(cfg[6:5]),
		.irq_any_i(src[0]), .adc_done_i(src[1]), .two_wire_irq_i(src[2]),
		.two_wire_match_i(src[3]), .t2_irq_i(src[4]), .spm_ready_i(src[5]),
		.wdog_irq_i(src[6]), .wdog_reset_i(src[7]), .bor_reset_i(src[8]),
		.pin_change_i(src[9]), .ext_reset_i(src[10]), .ext_level_i(src[18:11]),
		.ext_any_i(src[26:19]), .t2_evt_i(src[28:27]),
		.core_clk_en_o(en[7]), .flash_clk_en_o(en[6]), .io_clk_en_o(en[5]),
		.adc_clk_en_o(en[4]), .async_clk_en_o(en[3]), .main_osc_en_o(en[2]),
		.timer_osc_en_o(en[1]), .t2_sync_clk_en_o(en[0]), .adc_start_o(ast),
		.periph_acc_i(acc), .periph_clk_en_o(pclk), .periph_acc_ok_o(aok));
	smc_core_model i_smc_core_model (
		.clk_i(clk_i), .rst_n_i(rst_n), .go_i(go), .core_halt_i(halt),
		.wake_irq_i(wake), .reset_vector_i(rv), .sleep_instr_o(sl),
		.wake_cnt_o(wc), .rv_cnt_o(rvc));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task results();
		if (fail_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] a, input logic [7:0] e);
		checked++;
		if (a !== e) begin
			fail_count++;
			$display("BAD %0t %h %h", $time, a, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_i);
		wr_s <= 1'b0;
		@(posedge clk_i);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_i);
		rd_s <= 1'b0;
		#1 chk(rdata, e);
		@(posedge clk_i);
	endtask
	// write control, let the core issue sleep, return two edges later
	task enter(input logic [7:0] c);
		wr(SMC_SLEEP_CTRL_OFS, c);
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		@(posedge clk_i);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task regs();
		#1 chk(en, {6'h3f, cfg[3], 1'b0});
		chk(pclk, 8'hff);
		@(posedge clk_i);
		rd(SMC_SLEEP_CTRL_OFS, 8'h00);
		rd(SMC_CLK_GATE_OFS, 8'h00);
		rd(SMC_STATUS_OFS, 8'h00);
		wr(SMC_SLEEP_CTRL_OFS, 8'hff);
		rd(SMC_SLEEP_CTRL_OFS, 8'h0f);
		wr(SMC_CLK_GATE_OFS, 8'hff);
		rd(SMC_CLK_GATE_OFS, 8'hef);
		wr(SMC_CLK_GATE_OFS, 8'h00);
		rd(8'h10, 8'h00);
	endtask
	// nb: a source that must not wake (-1 none), b: the waking source
	task slp(input logic [7:0] c, input logic [7:0] ee, input int nb, input int b,
		input int ne);
		int n;
		logic [7:0] w0;
		w0 = wc;
		enter(c);
		#1 chk(ast, {7'h00, cfg[0] & (c[3:1] < 3'h2)});
		@(posedge clk_i);
		#1 chk(en, ee);
		chk(halt, 8'h01);
		@(posedge clk_i);
		if (nb >= 0) begin
			src[nb] <= 1'b1;
			repeat (6) @(posedge clk_i);
			#1 chk(halt, 8'h01);
			@(posedge clk_i);
			src[nb] <= 1'b0;
		end
		src[b] <= 1'b1;
		n = 0;
		// look 1 ns after each edge so the registered pulse has settled
		do begin
			@(posedge clk_i);
			#1 n++;
		end while (wake !== 1'b1 && n < 40);
		chk(8'(n), 8'(ne));
		chk(halt, 8'h00);
		chk(en, {6'h3f, cfg[3], 1'b0});
		@(posedge clk_i);
		src[b] <= 1'b0;
		#1 chk(wake, 8'h00);
		chk(wc - w0, 8'h01);
		@(posedge clk_i);
	endtask
	task nosl(input logic [7:0] c);
		enter(c);
		@(posedge clk_i);
		#1 chk(halt, 8'h00);
		chk(en, 8'hfc);
		@(posedge clk_i);
	endtask
	task rstsl();
		logic [7:0] r0;
		logic [7:0] w0;
		r0 = rvc;
		w0 = wc;
		enter(8'h05);
		@(posedge clk_i);
		src[7] <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1 chk(halt, 8'h00);
		chk(rvc - r0, 8'h01);
		chk(wc - w0, 8'h00);
		@(posedge clk_i);
		src[7] <= 1'b0;
		@(posedge clk_i);
	endtask
	task gate();
		// every peripheral keeps requesting register access while bits 0 and 7 are gated
		acc <= 8'hff;
		wr(SMC_CLK_GATE_OFS, 8'h81);
		#1 chk(pclk, 8'h7e);
		chk(aok, 8'h7e);
		@(posedge clk_i);
		wr(SMC_CLK_GATE_OFS, 8'h00);
		#1 chk(pclk, 8'hff);
		chk(aok, 8'hff);
		@(posedge clk_i);
		acc <= 8'h00;
	endtask
	// ------------------------------------------------------------
	// clock, timeout and main sequence
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			results();
		end
	end
	initial begin
		rst_n = 1'b0;
		{addr, wdata, wr_s, rd_s, go, src, acc} = '0;
		cfg = 7'h7f;
		fail_count = 0;
		checked = 0;
		cyc = 0;
		repeat (15) @(posedge clk_i);
		#1 chk(en, 8'hfc);
		chk(pclk, 8'hff);
		chk(halt, 8'h00);
		@(posedge clk_i);
		rst_n <= 1'b1;
		@(posedge clk_i);
		regs();
		slp(8'h01, 8'h3e, -1, 0, 5);
		cfg[3] <= 1'b0;
		slp(8'h03, 8'h14, 0, 1, 5);
		slp(8'h05, 8'h00, 26, 19, 11);
		slp(8'h07, 8'h05, 5, 27, 9);
		slp(8'h0d, 8'h04, 6, 3, 11);
		slp(8'h0f, 8'h05, 26, 27, 11);
		// without the global enable the timer event must not wake
		cfg[4] <= 1'b0;
		cfg[0] <= 1'b0;
		slp(8'h07, 8'h05, 27, 3, 9);
		slp(8'h01, 8'h34, 3, 0, 5);
		nosl(8'h00);
		nosl(8'h09);
		nosl(8'h0b);
		cfg[1] <= 1'b0;
		nosl(8'h0d);
		rstsl();
		gate();
		results();
	end
endmodule // smc_sleep_ctrl_tb
